// >>> verilog/nv_host_pkg.sv
package nv_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // access and cycle times of the memory
  localparam int ACCESS_NS = 70;
  localparam int CYCLE_NS = 140;
  // low phase covers access; high phase is the rest of the cycle (precharge)
  localparam int PRECHARGE_NS = CYCLE_NS - ACCESS_NS;
  // least times round up
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCESS,
    ST_PRECHARGE
  } host_state_t;
endpackage

// >>> verilog/nv_cycle_timer.sv
`timescale 1ns/1ps
module nv_cycle_timer
  import nv_host_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  output logic expired
);
  logic [CNT_W-1:0] count_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      count_r <= CNT_ZERO;
    end else if (clk_en) begin
      if (load) begin
        count_r <= load_value;
      end else if (count_r != CNT_ZERO) begin
        count_r <= count_r - CNT_ONE;
      end
    end
  end
  assign expired = (count_r == CNT_ZERO);
endmodule

// >>> verilog/nv_ram_host.sv
`timescale 1ns/1ps
module nv_ram_host
  import nv_host_pkg::*;
#(
  parameter int ACCESS_CYCLES = ACCESS_CYC,
  parameter int PRECHARGE_CYCLES = PRECHARGE_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic chip_sel_n,
  output logic store_n,
  output logic out_drive_n,
  output logic [ADDR_W-1:0] byte_select_lines,
  input wire logic [DATA_W-1:0] byte_lanes_i,
  output logic [DATA_W-1:0] byte_lanes_o,
  output logic byte_lanes_oe
);
  host_state_t state_r, state_nxt;
  logic write_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic rsp_valid_r;
  logic cs_n_r, we_n_r, oe_n_r, oe_r;
  logic timer_load;
  logic [CNT_W-1:0] timer_value;
  logic timer_done;
  logic write_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] wdata_nxt;
  logic [DATA_W-1:0] rdata_nxt;
  logic rsp_valid_nxt;
  logic cs_n_nxt;
  logic we_n_nxt;
  logic oe_n_nxt;
  logic oe_nxt;

  wire take_req = (state_r == ST_IDLE) && req_valid;
  wire setup_done = (state_r == ST_SETUP);
  wire access_done = (state_r == ST_ACCESS) && timer_done;
  wire pre_done = (state_r == ST_PRECHARGE) && timer_done;

  // new requests wait in idle until the precharge has run out
  assign req_ready = (state_r == ST_IDLE);
  assign timer_load = setup_done || access_done;
  // low phase spans the access, high phase the precharge
  // low time is held to the access time while clk_en is high; with clk_en low the select keeps its level
  assign timer_value = setup_done ? CNT_W'(ACCESS_CYCLES - 1) : CNT_W'(PRECHARGE_CYCLES - 1);

  nv_cycle_timer u_timer (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_done)
  );

  // one pass through the states per byte, so each access has its own select fall
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_nxt = ST_ACCESS;
      end
      ST_ACCESS: begin
        if (timer_done) begin
          state_nxt = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        if (timer_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // request capture; address stays steady through the whole cycle
  assign write_nxt = take_req ? req_write : write_r;
  assign addr_nxt = take_req ? req_addr : addr_r;
  assign wdata_nxt = take_req ? req_wdata : wdata_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      write_r <= 1'b0;
    end else if (clk_en) begin
      write_r <= write_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_r <= '0;
    end else if (clk_en) begin
      addr_r <= addr_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wdata_r <= '0;
    end else if (clk_en) begin
      wdata_r <= wdata_nxt;
    end
  end

  // strobes: address set up one cycle, then chip select falls per access
  // strobe low before chip select, so the memory never drives in a write
  assign we_n_nxt = take_req ? ~req_write : (pre_done ? 1'b1 : we_n_r);
  assign oe_nxt = take_req ? req_write : (pre_done ? 1'b0 : oe_r);
  // write ends at chip select rise; strobe and data stay held until the precharge ends
  assign cs_n_nxt = setup_done ? 1'b0 : (access_done ? 1'b1 : cs_n_r);
  assign oe_n_nxt = setup_done ? write_r : (access_done ? 1'b1 : oe_n_r);

  always_ff @(posedge clock) begin
    if (rst) begin
      cs_n_r <= 1'b1;
    end else if (clk_en) begin
      cs_n_r <= cs_n_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      we_n_r <= 1'b1;
    end else if (clk_en) begin
      we_n_r <= we_n_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      oe_n_r <= 1'b1;
    end else if (clk_en) begin
      oe_n_r <= oe_n_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else if (clk_en) begin
      oe_r <= oe_nxt;
    end
  end

  // read data sampled at end of access, before chip select rises
  assign rdata_nxt = (access_done && !write_r) ? byte_lanes_i : rdata_r;
  assign rsp_valid_nxt = access_done;

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_r <= rsp_valid_nxt;
    end
  end

  assign chip_sel_n = cs_n_r;
  assign store_n = we_n_r;
  assign out_drive_n = oe_n_r;
  assign byte_select_lines = addr_r;
  assign byte_lanes_o = wdata_r;
  assign byte_lanes_oe = oe_r;
  // one pulse per access, writes included, so no polling is needed
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rdata_r;
endmodule

// >>> bench/nv_ram_host_assertions.sv
`timescale 1ns/1ps
module nv_host_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic store_n,
  input wire logic out_drive_n,
  input wire logic byte_lanes_oe,
  input wire logic req_ready,
  input wire logic rsp_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  no_clash_a: assert property (byte_lanes_oe |-> out_drive_n) else $error("bus clash");
  write_type_a: assert property ($fell(chip_sel_n) && !store_n |-> byte_lanes_oe) else $error("no write data");
  read_drive_a: assert property ($fell(chip_sel_n) && store_n |-> !out_drive_n && !byte_lanes_oe)
    else $error("read not enabled");
  strobe_lead_a: assert property ($fell(store_n) |=> $fell(chip_sel_n)) else $error("strobe order");
  low_time_a: assert property ($fell(chip_sel_n) |-> !chip_sel_n[*7] ##1 chip_sel_n)
    else $error("select low time");
  precharge_a: assert property ($rose(chip_sel_n) |-> chip_sel_n[*7]) else $error("precharge short");
  answer_a: assert property ($rose(chip_sel_n) |-> ##[0:1] rsp_valid) else $error("no answer");
  busy_a: assert property (!chip_sel_n |-> !req_ready) else $error("busy lost");
  drive_gate_a: assert property (chip_sel_n |-> out_drive_n) else $error("drive while deselected");
  cover property ($fell(chip_sel_n) && !store_n);
  cover property ($fell(chip_sel_n) && store_n);
  cover property (rsp_valid);
endmodule
bind nv_ram_host nv_host_chk nv_host_chk_inst (
  .clock(clock),
  .rst(rst),
  .chip_sel_n(chip_sel_n),
  .store_n(store_n),
  .out_drive_n(out_drive_n),
  .byte_lanes_oe(byte_lanes_oe),
  .req_ready(req_ready),
  .rsp_valid(rsp_valid)
);

// >>> bench/nv_mem_model.sv
`timescale 1ns/1ps
module nv_mem_model (
  input wire logic chip_sel_n,
  input wire logic store_n,
  input wire logic out_drive_n,
  input wire logic [14:0] byte_select_lines,
  input wire logic [7:0] byte_lanes_o,
  input wire logic byte_lanes_oe,
  output logic [7:0] lanes
);
  logic [7:0] mem [0:32767];
  logic [14:0] lat_r;
  logic wr_r = 0, ok_r = 0;
  logic [7:0] last_r = 8'h00;
  wire drv = ok_r && store_n && !out_drive_n && !chip_sel_n;
  assign lanes = byte_lanes_oe ? byte_lanes_o : drv ? mem[lat_r] : ~last_r;
  always @(negedge chip_sel_n) begin
    lat_r = byte_select_lines;
    wr_r = !store_n;
    ok_r = 0;
    #69 ok_r = !wr_r;
  end
  always @(posedge chip_sel_n) begin
    if (wr_r) mem[lat_r] = byte_lanes_o;
    ok_r = 0;
    last_r = lanes;
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import nv_host_pkg::*;
  logic clock = 0, rst = 1, clk_en = 1, req_valid = 0, req_write = 0;
  logic [ADDR_W-1:0] req_addr = '0, byte_select_lines;
  logic [DATA_W-1:0] req_wdata = '0, q, lanes, rsp_rdata, byte_lanes_o;
  logic req_ready, rsp_valid, chip_sel_n, store_n, out_drive_n, byte_lanes_oe;
  int miscompares = 0, checked = 0, cycles = 0;
  initial forever #5 clock = ~clock;
  nv_ram_host nv_ram_host_inst (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata),
    .chip_sel_n(chip_sel_n),
    .store_n(store_n),
    .out_drive_n(out_drive_n),
    .byte_select_lines(byte_select_lines),
    .byte_lanes_i(lanes),
    .byte_lanes_o(byte_lanes_o),
    .byte_lanes_oe(byte_lanes_oe)
  );
  nv_mem_model nv_mem_model_inst (
    .chip_sel_n(chip_sel_n),
    .store_n(store_n),
    .out_drive_n(out_drive_n),
    .byte_select_lines(byte_select_lines),
    .byte_lanes_o(byte_lanes_o),
    .byte_lanes_oe(byte_lanes_oe),
    .lanes(lanes)
  );
  task automatic test_done();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && ++n < 40) @(negedge clock);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clock);
    req_valid = 0;
    do @(negedge clock); while (rsp_valid !== 1'b1 && ++n < 40);
    q = rsp_rdata;
    check({7'h00, rsp_valid}, 8'h01);
  endtask
  task automatic t_idle();
    check({4'h0, chip_sel_n, store_n, out_drive_n, byte_lanes_oe}, 8'h0E);
  endtask
  task automatic t_edges();
    xfer(1, 15'h0000, 8'hA5);
    xfer(1, 15'h7FFF, 8'h5A);
    check(nv_mem_model_inst.mem[15'h7FFF], 8'h5A);
    xfer(0, 15'h0000, 8'h00);
    check(q, 8'hA5);
    xfer(0, 15'h7FFF, 8'h00);
    check(q, 8'h5A);
  endtask
  task automatic t_rewrite();
    xfer(1, 15'h1234, 8'h3C);
    xfer(1, 15'h1234, 8'hC3);
    xfer(0, 15'h1234, 8'h00);
    check(q, 8'hC3);
    xfer(0, 15'h1234, 8'h00);
    check(q, 8'hC3);
  endtask
  task automatic t_freeze();
    xfer(1, 15'h0F0F, 8'h69);
    clk_en = 0;
    repeat (20) @(negedge clock);
    check({3'h0, req_ready, rsp_valid, chip_sel_n, store_n, byte_lanes_oe}, 8'h0D);
    clk_en = 1;
    xfer(0, 15'h0F0F, 8'h00);
    check(q, 8'h69);
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst = 0;
    t_idle();
    t_edges();
    t_rewrite();
    t_freeze();
    test_done();
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      test_done();
    end
  end
endmodule
